//--- period_timer_pkg.sv
// Purpose: constants and types shared by the period match timer
// Assumes: 8-bit register port, word index addressing
// Notes:   register offsets are indices on the plain register port
package period_timer_pkg;
   localparam int          ADDR_W          = 3;
   localparam int          DATA_W          = 8;
   localparam logic [2:0]  ADDR_COUNT      = 3'h0;
   localparam logic [2:0]  ADDR_PERIOD     = 3'h1;
   localparam logic [2:0]  ADDR_CONTROL    = 3'h2;
   localparam logic [2:0]  ADDR_STATUS     = 3'h3;
   localparam logic [2:0]  ADDR_MASK       = 3'h4;
   localparam logic [7:0]  COUNT_RESET     = 8'h00;
   localparam logic [7:0]  PERIOD_RESET    = 8'hff;
   localparam logic [6:0]  CONTROL_RESET   = 7'h00;
   localparam int          POST_LSB        = 3;
   localparam int          RUN_BIT         = 2;
   localparam logic [3:0]  PRE_DIV1_LAST   = 4'h0;
   localparam logic [3:0]  PRE_DIV4_LAST   = 4'h3;
   localparam logic [3:0]  PRE_DIV16_LAST  = 4'hf;
   localparam logic [1:0]  PRE_SEL_DIV1    = 2'h0;
   localparam logic [1:0]  PRE_SEL_DIV4    = 2'h1;
   localparam int          MATCH_FLAG_BIT  = 0;

   typedef struct packed {
      logic [3:0] postscale_select;
      logic       timer_run;
      logic [1:0] prescale_select;
   } control_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_type;
endpackage

//--- period_match_timer.sv
// Purpose: 8-bit period timer with prescaler, postscaler and match interrupt
// Assumes: clock is the instruction clock; plain register port, read data one cycle later
// Notes:   status bit 0 is the match interrupt flag, cleared by writing a one
`timescale 1ns/1ns
`default_nettype none
module period_match_timer
   import period_timer_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              srst,
   input  wire reg_req_type       req,
   output logic [DATA_W-1:0]      rdata,
   output logic                   irq,
   output logic                   match_pulse
);
   logic [7:0]  timer_count_r;
   logic [7:0]  period_limit_r;
   control_type control_r;
   logic [3:0]  pre_cnt_r;
   logic [3:0]  post_cnt_r;
   logic        flag_r;
   logic        mask_r;
   logic [7:0]  rdata_r;
   logic        pre_tick;
   logic        match;
   logic        count_tick;
   logic        post_tick;
   logic        wr_count;
   logic        wr_control;
   logic        wr_status;
   logic [3:0]  pre_last;
   logic [4:0]  tick_gap_r;

   function automatic logic hit(input logic [2:0] a);
      hit = req.wr && (req.addr == a);
   endfunction

   assign wr_count   = hit(ADDR_COUNT);
   assign wr_control = hit(ADDR_CONTROL);
   assign wr_status  = hit(ADDR_STATUS);

   always_comb begin
      unique case (control_r.prescale_select)
         PRE_SEL_DIV1: pre_last = PRE_DIV1_LAST;
         PRE_SEL_DIV4: pre_last = PRE_DIV4_LAST;
         default:      pre_last = PRE_DIV16_LAST;
      endcase
   end

   // prescaler runs only with the timer and clears while stopped, so a restarted timer begins a fresh divide
   assign pre_tick   = control_r.timer_run && (pre_cnt_r == pre_last);
   assign match      = (timer_count_r == period_limit_r);
   assign count_tick = pre_tick && !wr_count && !wr_control;
   assign post_tick  = count_tick && match && (post_cnt_r == control_r.postscale_select);

   always_ff @(posedge clock) begin
      if (srst || wr_count || wr_control || !control_r.timer_run) begin
         pre_cnt_r <= '0;
      end else if (pre_tick) begin
         pre_cnt_r <= '0;
      end else begin
         pre_cnt_r <= pre_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst || wr_count || wr_control) begin
         post_cnt_r <= '0;
      end else if (count_tick && match) begin
         if (post_cnt_r == control_r.postscale_select) begin
            post_cnt_r <= '0;
         end else begin
            post_cnt_r <= post_cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         timer_count_r <= COUNT_RESET;
      end else if (wr_count) begin
         timer_count_r <= req.wdata;
      end else if (count_tick) begin
         if (match) begin
            timer_count_r <= COUNT_RESET;
         end else begin
            timer_count_r <= timer_count_r + 8'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         period_limit_r <= PERIOD_RESET;
      end else if (hit(ADDR_PERIOD)) begin
         period_limit_r <= req.wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         control_r <= CONTROL_RESET;
      end else if (wr_control) begin
         control_r <= req.wdata[6:0];
      end
   end

   // set wins over a same-cycle clear
   always_ff @(posedge clock) begin
      if (srst) begin
         flag_r <= 1'b0;
      end else if (post_tick) begin
         flag_r <= 1'b1;
      end else if (wr_status && req.wdata[MATCH_FLAG_BIT]) begin
         flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         mask_r <= 1'b0;
      end else if (hit(ADDR_MASK)) begin
         mask_r <= req.wdata[MATCH_FLAG_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_r <= '0;
      end else if (req.rd) begin
         unique case (req.addr)
            ADDR_COUNT:   rdata_r <= timer_count_r;
            ADDR_PERIOD:  rdata_r <= period_limit_r;
            ADDR_CONTROL: rdata_r <= {1'b0, control_r};
            ADDR_STATUS:  rdata_r <= {7'h00, flag_r};
            ADDR_MASK:    rdata_r <= {7'h00, mask_r};
            default:      rdata_r <= '0;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   assign rdata       = rdata_r;
   assign irq         = flag_r && mask_r;
   assign match_pulse = count_tick && match;

   // checking aid only: cycles since the last tick or scaler clear, measured apart from the prescaler
   always_ff @(posedge clock) begin
      if (srst || wr_count || wr_control || count_tick) begin
         tick_gap_r <= '0;
      end else if (tick_gap_r != '1) begin
         tick_gap_r <= tick_gap_r + 5'h01;
      end
   end

   prescale_tick_a : assert property (
      @(posedge clock) disable iff (srst)
      count_tick |-> control_r.timer_run
   ) else $error("count ticked while stopped");

   count_hold_a : assert property (
      @(posedge clock) disable iff (srst)
      (!control_r.timer_run && !req.wr) |=> $stable(timer_count_r)
   ) else $error("count moved while stopped");

   div16_space_a : assert property (
      @(posedge clock) disable iff (srst)
      (count_tick && control_r.prescale_select[1]) |-> (tick_gap_r == {1'b0, PRE_DIV16_LAST})
   ) else $error("tick spacing at div16");

   div4_space_a : assert property (
      @(posedge clock) disable iff (srst)
      (count_tick && control_r.prescale_select == PRE_SEL_DIV4) |-> (tick_gap_r == {1'b0, PRE_DIV4_LAST})
   ) else $error("tick spacing at div4");

   div1_tick_a : assert property (
      @(posedge clock) disable iff (srst)
      (control_r.timer_run && control_r.prescale_select == PRE_SEL_DIV1 && !wr_count && !wr_control) |-> count_tick
   ) else $error("missed tick at div1");

   pre_bound_a : assert property (
      @(posedge clock) disable iff (srst)
      pre_cnt_r <= pre_last
   ) else $error("prescaler past its limit");

   stop_clear_a : assert property (
      @(posedge clock) disable iff (srst)
      !control_r.timer_run |=> (pre_cnt_r == '0)
   ) else $error("prescaler moved while stopped");

   wrap_zero_a : assert property (
      @(posedge clock) disable iff (srst)
      (count_tick && match && !req.wr) |=> (timer_count_r == COUNT_RESET)
   ) else $error("no wrap on match");

   count_step_a : assert property (
      @(posedge clock) disable iff (srst)
      (count_tick && !match) |=> (timer_count_r == $past(timer_count_r) + 8'h01)
   ) else $error("bad step");

   pulse_run_a : assert property (
      @(posedge clock) disable iff (srst)
      match_pulse |-> (timer_count_r == period_limit_r && control_r.timer_run)
   ) else $error("match pulse without match");

   ctrl_keep_a : assert property (
      @(posedge clock) disable iff (srst)
      (wr_control && !wr_count) |=> $stable(timer_count_r)
   ) else $error("control write changed count");

   scaler_clear_a : assert property (
      @(posedge clock) disable iff (srst)
      (wr_count || wr_control) |=> (pre_cnt_r == 4'h0 && post_cnt_r == 4'h0)
   ) else $error("scaler not cleared");

   post_step_a : assert property (
      @(posedge clock) disable iff (srst)
      (count_tick && match && (post_cnt_r != control_r.postscale_select)) |=> (post_cnt_r == $past(post_cnt_r) + 4'h1)
   ) else $error("postscaler did not advance");

   post_hold_a : assert property (
      @(posedge clock) disable iff (srst)
      (!(count_tick && match) && !wr_count && !wr_control) |=> $stable(post_cnt_r)
   ) else $error("postscaler moved without match");

   post_ratio_a : assert property (
      @(posedge clock) disable iff (srst)
      post_tick |-> (post_cnt_r == control_r.postscale_select)
   ) else $error("postscale ratio");

   post_fire_a : assert property (
      @(posedge clock) disable iff (srst)
      (count_tick && match && (post_cnt_r == control_r.postscale_select)) |=> (post_cnt_r == '0)
   ) else $error("postscaler did not wrap");

   post_bound_a : assert property (
      @(posedge clock) disable iff (srst)
      post_cnt_r <= control_r.postscale_select
   ) else $error("postscaler past its limit");

   flag_set_a : assert property (
      @(posedge clock) disable iff (srst)
      post_tick |=> flag_r
   ) else $error("flag not set");

   flag_rise_a : assert property (
      @(posedge clock) disable iff (srst)
      (!flag_r && !post_tick) |=> !flag_r
   ) else $error("flag set without postscaler output");

   flag_keep_a : assert property (
      @(posedge clock) disable iff (srst)
      (flag_r && !wr_status) |=> flag_r
   ) else $error("flag dropped");

   flag_zero_a : assert property (
      @(posedge clock) disable iff (srst)
      (flag_r && wr_status && !req.wdata[MATCH_FLAG_BIT]) |=> flag_r
   ) else $error("flag dropped on write of zero");

   flag_clear_a : assert property (
      @(posedge clock) disable iff (srst)
      (wr_status && req.wdata[MATCH_FLAG_BIT] && !post_tick) |=> !flag_r
   ) else $error("flag not cleared");

   wr_count_a : assert property (
      @(posedge clock) disable iff (srst)
      (req.wr && req.addr == ADDR_COUNT) |=> (timer_count_r == $past(req.wdata))
   ) else $error("count write lost");

   wr_period_a : assert property (
      @(posedge clock) disable iff (srst)
      (req.wr && req.addr == ADDR_PERIOD) |=> (period_limit_r == $past(req.wdata))
   ) else $error("period write lost");

   period_hold_a : assert property (
      @(posedge clock) disable iff (srst)
      !(req.wr && req.addr == ADDR_PERIOD) |=> $stable(period_limit_r)
   ) else $error("period changed without write");

   ctrl_hold_a : assert property (
      @(posedge clock) disable iff (srst)
      !wr_control |=> $stable(control_r)
   ) else $error("control changed without write");

   rd_count_a : assert property (
      @(posedge clock) disable iff (srst)
      (req.rd && req.addr == ADDR_COUNT) |=> (rdata == $past(timer_count_r))
   ) else $error("count read data");

   rd_period_a : assert property (
      @(posedge clock) disable iff (srst)
      (req.rd && req.addr == ADDR_PERIOD) |=> (rdata == $past(period_limit_r))
   ) else $error("period read data");

   rd_control_a : assert property (
      @(posedge clock) disable iff (srst)
      (req.rd && req.addr == ADDR_CONTROL) |=> (rdata == {1'b0, $past(control_r)})
   ) else $error("control read data");

   rd_status_a : assert property (
      @(posedge clock) disable iff (srst)
      (req.rd && req.addr == ADDR_STATUS) |=> (rdata == {7'h00, $past(flag_r)})
   ) else $error("status read data");

   rd_mask_a : assert property (
      @(posedge clock) disable iff (srst)
      (req.rd && req.addr == ADDR_MASK) |=> (rdata == {7'h00, $past(mask_r)})
   ) else $error("mask read data");

   rd_unmapped_a : assert property (
      @(posedge clock) disable iff (srst)
      (req.rd && req.addr > ADDR_MASK) |=> (rdata == '0)
   ) else $error("unmapped read not zero");

   rd_idle_a : assert property (
      @(posedge clock) disable iff (srst)
      !req.rd |=> (rdata == '0)
   ) else $error("read data outside its cycle");

   reset_val_a : assert property (
      @(posedge clock)
      srst |=> (timer_count_r == COUNT_RESET && period_limit_r == PERIOD_RESET)
   ) else $error("reset values");

   reset_ctrl_a : assert property (
      @(posedge clock)
      srst |=> (control_r == CONTROL_RESET && !flag_r && !mask_r && pre_cnt_r == '0 && post_cnt_r == '0 && rdata == '0)
   ) else $error("reset state of control and scalers");
endmodule
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for the period match timer
// Assumes: register port with read data in the cycle after the read strobe
// Notes:   reads are queued by the driver and compared by a separate monitor
`timescale 1ns/1ns
`default_nettype none
module tb
   import period_timer_pkg::*;
;
   logic              clock = 1'b0;
   logic              srst = 1'b1;
   logic              rd_d = 1'b0;
   reg_req_type       req = '0;
   logic [DATA_W-1:0] rdata;
   logic              irq;
   logic              match_pulse;
   logic [7:0]        q[$];
   logic [7:0]        v;
   logic [31:0]       seed = 32'd39397;
   logic [7:0]        pre_exp [4] = '{8'h40, 8'h10, 8'h04, 8'h04};
   logic [3:0]        posts [3] = '{4'h0, 4'h5, 4'hf};
   int                n_mismatch = 0;
   int                samples_checked = 0;
   int                pulses;

   always #25 clock = ~clock;

   period_match_timer u_dut (.clock(clock), .srst(srst), .req(req), .rdata(rdata), .irq(irq),
                             .match_pulse(match_pulse));

   function logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   task automatic check(string name, logic [7:0] exp, logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one idle cycle between strobes so no signal is driven twice in one step
   task automatic access(logic [2:0] a, logic [7:0] d, logic w);
      req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
   endtask

   task automatic wr(logic [2:0] a, logic [7:0] d);
      access(a, d, 1'b1);
   endtask

   task automatic rd(logic [2:0] a, logic [7:0] exp);
      q.push_back(exp);
      access(a, 8'h00, 1'b0);
   endtask

   task stop_test;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // read data stands only in the cycle after the strobe, so look mid-cycle
   always @(posedge clock) rd_d <= req.rd;
   always @(negedge clock) begin
      if (rd_d) check("rdata", q.pop_front(), rdata);
   end

   initial begin
      repeat (100000) @(posedge clock);
      n_mismatch++;
      stop_test();
   end

   initial begin
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      rd(ADDR_COUNT, COUNT_RESET);
      rd(ADDR_PERIOD, PERIOD_RESET);
      rd(ADDR_CONTROL, 8'h00);
      rd(ADDR_STATUS, 8'h00);
      rd(ADDR_MASK, 8'h00);
      rd(3'h5, 8'h00);
      wr(ADDR_CONTROL, 8'hff);
      rd(ADDR_CONTROL, 8'h7f);
      wr(ADDR_CONTROL, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         wr(ADDR_PERIOD, v);
         rd(ADDR_PERIOD, v);
         wr(ADDR_COUNT, v ^ 8'h5a);
         rd(ADDR_COUNT, v ^ 8'h5a);
      end
      wr(ADDR_PERIOD, 8'hff);
      // 64 cycles of run: a multiple of every divide, whatever phase the first tick takes
      for (int s = 0; s < 4; s++) begin
         wr(ADDR_COUNT, 8'h00);
         wr(ADDR_CONTROL, 8'h04 | 8'(s));
         repeat (63) @(posedge clock);
         wr(ADDR_CONTROL, 8'h00);
         rd(ADDR_COUNT, pre_exp[s]);
         repeat (10) @(posedge clock);
         rd(ADDR_COUNT, pre_exp[s]);
      end
      wr(ADDR_PERIOD, 8'h03);
      wr(ADDR_MASK, 8'h01);
      for (int p = 0; p < 3; p++) begin
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_STATUS, 8'h01);
         wr(ADDR_COUNT, 8'h00);
         wr(ADDR_CONTROL, {1'b0, posts[p], 1'b1, 2'b00});
         pulses = 0;
         for (int c = 0; c < 300 && irq !== 1'b1; c++) begin
            @(negedge clock);
            if (match_pulse === 1'b1 && irq !== 1'b1) pulses++;
         end
         @(posedge clock);
         if (irq !== 1'b1) begin
            n_mismatch++;
            stop_test();
         end
         check("matches", {4'h0, posts[p]} + 8'h01, 8'(pulses));
      end
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, 8'h01);
      wr(ADDR_MASK, 8'h00);
      check("irq", 8'h00, {7'h00, irq});
      wr(ADDR_STATUS, 8'h01);
      rd(ADDR_STATUS, 8'h00);
      wr(ADDR_MASK, 8'h01);
      check("irq", 8'h00, {7'h00, irq});
      stop_test();
   end
endmodule
`default_nettype wire
